//--- settings_bank.v
// holding-register bank of the flow meter: info, user and service sections
// ============================================================
// What this block does
// R1: read-only unit serial number, 0..39999999
// R2: count minutes measurement was suspended by error
// R3: count minutes meter measured correctly
// R4: read-only firmware version, diameter, nominal flow copies
// R5: user password 1111 opens user section
// R6: run/stop 1 freezes totalizers, reset 1
// R7: empty-pipe enabled and sensed: excitation off, error
// R8: empty-pipe limit compared, default 188
// R9: average samples 1..30, default 15
// R10: low-flow cutoff code 0..5, default 3
// R11: invert setting reverses reported flow direction
// R12: writing one starts electrode cleaning
// R13: nonzero write clears auxiliary positive totalizer
// R14: slave address 1..247, default 1
// R15: bit rate from six values, default 9600
// R16: parity code selects framing, default 3
// R17: start delay excludes measurements from totalizers
// R18: service password opens service section
// R19: nonzero write clears ok/error minute counter
// R20: total, negative, positive clears act independently
// R21: simulation switch 0 selects simulated flow value
// R22: writable nominal flow, default 3600
// R23: items accessed as even-aligned low/high pairs
// R24: password read shows open state; invalid closes
`timescale 1ns/100ps
`include "settings_bank_map.vh"
module settings_bank #(
   parameter [31:0] UNIT_SERIAL   = 32'h0000_0001,
   parameter [31:0] DIAMETER      = 32'h0000_0032,
   parameter [31:0] FIRMWARE_VER  = 32'h0000_0064,
   parameter [31:0] SERVICE_PW    = `SERVICE_PASSWORD,
   parameter        CYCLES_PER_S  = `CLK_HZ / `SECOND_S,
   parameter        SECONDS_PER_M = `MINUTE_S
) (
   input  wire        i_clk,
   input  wire        i_rst_n,
   // register access from the frame decoder
   input  wire        i_req,
   input  wire        i_write,
   input  wire [15:0] i_reg,
   input  wire [7:0]  i_count,
   input  wire [31:0] i_wdata,
   output reg         o_ack,
   output reg  [31:0] o_rdata,
   output reg  [7:0]  o_exception,
   // measurement status
   input  wire        i_meas_ok,
   input  wire        i_meas_error,
   input  wire        i_pipe_empty,
   input  wire [31:0] i_empty_data,
   input  wire [31:0] i_flow,
   input  wire        i_flow_neg,
   // settings towards measurement
   output reg         o_total_enable,
   output reg         o_excitation_off,
   output reg         o_empty_pipe_error,
   output reg  [4:0]  o_avg_samples,
   output reg  [2:0]  o_low_flow_cut,
   output reg  [31:0] o_nominal_flow,
   output reg  [31:0] o_flow_used,
   output reg         o_flow_neg,
   output reg         o_clean_start,
   output reg         o_clear_aux,
   output reg         o_clear_total,
   output reg         o_clear_neg,
   output reg         o_clear_pos,
   output reg  [7:0]  o_slave_address,
   output reg  [31:0] o_bit_rate,
   output reg  [1:0]  o_parity_code,
   output reg         o_parity_en,
   output reg         o_parity_odd,
   output reg         o_two_stop
);
   // ============================================================
   // settings storage
   // user section
   reg [31:0] run_stop_r;
   reg [31:0] empty_en_r;
   reg [31:0] empty_limit_r;
   reg [31:0] avg_r;
   reg [31:0] cut_r;
   reg [31:0] inv_r;
   reg [31:0] nominal_r;
   reg [31:0] addr_r;
   reg [31:0] rate_r;
   reg [31:0] parity_r;
   reg [31:0] delay_r;

   // service section
   reg [31:0] sim_sw_r;
   reg [31:0] sim_flow_r;

   // password state
   reg        user_open_r;
   reg        svc_open_r;

   // start delay and timebase
   reg [31:0] delay_cnt_r;
   reg        delay_done_r;
   wire       sec_tick;
   wire       min_tick;
   wire [31:0] err_min;
   wire [31:0] ok_min;

   // ============================================================
   // decode helpers
   // section membership, both ends included
   function in_range;
      input [15:0] addr;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_range = (addr >= lo) && (addr <= hi);
      end
   endfunction

   // empty pipe seen on the pin or by data above the limit
   function empty_seen;
      input        pipe_empty;
      input [31:0] data;
      input [31:0] limit;
      begin
         empty_seen = pipe_empty || (data > limit);
      end
   endfunction

   // accepted write of a nonzero value to one trigger register
   function trig_hit;
      input        wr;
      input [15:0] addr;
      input [15:0] target;
      input [31:0] data;
      begin
         trig_hit = wr && (addr == target) && (data != 32'h0000_0000);
      end
   endfunction

   // serial framing of a parity code: parity on, odd, two stops
   function [2:0] framing;
      input [1:0] code;
      begin
         framing = {(code[1] == 1'b0), (code == 2'h1), (code == 2'h2)};
      end
   endfunction

   // ============================================================
   // request decode
   wire in_user = in_range(i_reg, `REG_RUN_STOP, `REG_PWRUP_DELAY);
   wire in_svc  = in_range(i_reg, `REG_OK_CLEAR, `REG_SIM_FLOW);
   wire in_info = in_range(i_reg, `REG_UNIT_SERIAL, `REG_NOMINAL_INFO);
   wire is_pw   = (i_reg == `REG_PW_USER) || (i_reg == `REG_PW_SERVICE);
   // pair alignment: even start and exactly two registers
   wire aligned = (i_reg[0] == 1'b0) && (i_count == 8'h02); // R23
   wire mapped  = in_info || is_pw
                  || ((in_user && user_open_r) || (in_svc && svc_open_r)); // R5 R18
   wire wr_ok   = aligned && mapped && !(in_info && i_write);
   wire do_wr   = i_req && i_write && wr_ok;

   // ============================================================
   // timebase
   tick_divider #(.DIV(CYCLES_PER_S)) u_sec (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_tick_in (1'b1),
      .o_tick    (sec_tick)
   );
   tick_divider #(.DIV(SECONDS_PER_M)) u_min (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_tick_in (sec_tick),
      .o_tick    (min_tick)
   );

   // ============================================================
   // minute counters
   minute_counter #(.WIDTH(32)) u_err (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_minute   (min_tick),
      .i_count_en (i_meas_error), // R2
      .i_clear    (trig_hit(do_wr, i_reg, `REG_ERR_CLEAR, i_wdata)), // R19
      .o_count    (err_min)
   );
   minute_counter #(.WIDTH(32)) u_ok (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_minute   (min_tick),
      .i_count_en (i_meas_ok && !i_meas_error), // R3
      .i_clear    (trig_hit(do_wr, i_reg, `REG_OK_CLEAR, i_wdata)), // R19
      .o_count    (ok_min)
   );

   // ============================================================
   // register writes
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_stop_r  <= `RST_RUN_STOP;
         empty_en_r  <= `RST_EMPTY_PIPE_EN;
         empty_limit_r <= `RST_EMPTY_LIMIT;
         avg_r       <= `RST_AVG_SAMPLES;
         cut_r       <= `RST_LOW_FLOW_CUT;
         inv_r       <= `RST_DIR_INVERT;
         nominal_r   <= `RST_NOMINAL_USER;
         addr_r      <= `RST_SLAVE_ADDR;
         rate_r      <= `RST_BIT_RATE;
         parity_r    <= `RST_PARITY;
         delay_r     <= `RST_PWRUP_DELAY;
         sim_sw_r    <= `RST_SIM_SWITCH;
         sim_flow_r  <= 32'h0000_0000;
         user_open_r <= 1'b0;
         svc_open_r  <= 1'b0;
         o_clean_start <= 1'b0;
         o_clear_aux   <= 1'b0;
         o_clear_total <= 1'b0;
         o_clear_neg   <= 1'b0;
         o_clear_pos   <= 1'b0;
      end else begin
         o_clean_start <= do_wr && (i_reg == `REG_CLEAN_TRIG) && (i_wdata == 32'h0000_0001); // R12
         o_clear_aux   <= trig_hit(do_wr, i_reg, `REG_AUX_CLEAR, i_wdata); // R13
         o_clear_total <= trig_hit(do_wr, i_reg, `REG_TOTAL_CLEAR, i_wdata); // R20
         o_clear_neg   <= trig_hit(do_wr, i_reg, `REG_NEG_CLEAR, i_wdata); // R20
         o_clear_pos   <= trig_hit(do_wr, i_reg, `REG_POS_CLEAR, i_wdata); // R20
         if (do_wr) begin
            case (i_reg)
               `REG_PW_USER:       user_open_r <= (i_wdata == `USER_PASSWORD); // R5 R24
               `REG_PW_SERVICE:    svc_open_r <= (i_wdata == SERVICE_PW); // R18 R24
               `REG_RUN_STOP:      run_stop_r <= i_wdata; // R6
               `REG_EMPTY_PIPE_EN: empty_en_r <= i_wdata; // R7
               `REG_EMPTY_LIMIT:   empty_limit_r <= i_wdata; // R8
               `REG_AVG_SAMPLES:   avg_r <= i_wdata; // R9
               `REG_LOW_FLOW_CUT:  cut_r <= i_wdata; // R10
               `REG_DIR_INVERT:    inv_r <= i_wdata; // R11
               `REG_NOMINAL_USER:  nominal_r <= i_wdata; // R22
               `REG_SLAVE_ADDR:    addr_r <= i_wdata; // R14
               `REG_BIT_RATE:      rate_r <= i_wdata; // R15
               `REG_PARITY:        parity_r <= i_wdata; // R16
               `REG_PWRUP_DELAY:   delay_r <= i_wdata; // R17
               `REG_SIM_SWITCH:    sim_sw_r <= i_wdata; // R21
               `REG_SIM_FLOW:      sim_flow_r <= i_wdata; // R21
               default: ;
            endcase
         end
      end
   end

   // ============================================================
   // start delay after power-up
   // a zero delay releases the totalizers at once
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         delay_cnt_r  <= 32'h0000_0000;
         delay_done_r <= 1'b0;
      end else if (!delay_done_r && sec_tick) begin
         if (delay_cnt_r + 32'h0000_0001 >= delay_r) begin
            delay_done_r <= 1'b1; // R17
         end
         delay_cnt_r <= delay_cnt_r + 32'h0000_0001;
      end else if (!delay_done_r && (delay_r == 32'h0000_0000)) begin
         delay_done_r <= 1'b1; // R17
      end
   end

   // ============================================================
   // outputs towards measurement
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_total_enable     <= 1'b0;
         o_excitation_off   <= 1'b0;
         o_empty_pipe_error <= 1'b0;
         o_avg_samples      <= 5'h0f;
         o_low_flow_cut     <= 3'h3;
         o_nominal_flow     <= `RST_NOMINAL_USER;
         o_flow_used        <= 32'h0000_0000;
         o_flow_neg         <= 1'b0;
         o_slave_address    <= 8'h01;
         o_bit_rate         <= `RST_BIT_RATE;
         o_parity_code      <= 2'h3;
         o_parity_en        <= 1'b0;
         o_parity_odd       <= 1'b0;
         o_two_stop         <= 1'b0;
      end else begin
         o_total_enable <= (run_stop_r[0] == 1'b0) && delay_done_r; // R6 R17
         // sensing uses the limit and enable bit 0 low
         o_empty_pipe_error <= (empty_en_r[0] == 1'b0)
                               && empty_seen(i_pipe_empty, i_empty_data, empty_limit_r); // R7 R8
         o_excitation_off   <= (empty_en_r[0] == 1'b0)
                               && empty_seen(i_pipe_empty, i_empty_data, empty_limit_r); // R7
         o_avg_samples  <= avg_r[4:0]; // R9
         o_low_flow_cut <= cut_r[2:0]; // R10
         o_nominal_flow <= nominal_r; // R22
         o_flow_used    <= (sim_sw_r[0] == 1'b0) ? sim_flow_r : i_flow; // R21
         o_flow_neg     <= i_flow_neg ^ inv_r[0]; // R11
         o_slave_address <= addr_r[7:0]; // R14
         o_bit_rate     <= rate_r; // R15
         o_parity_code  <= parity_r[1:0]; // R16
         {o_parity_en, o_parity_odd, o_two_stop} <= framing(parity_r[1:0]); // R16
      end
   end

   // ============================================================
   // read path and answer
   reg [31:0] rd_nxt;
   // trigger registers read back as zero
   always @* begin
      case (i_reg)
         `REG_PW_USER:       rd_nxt = {31'h0, user_open_r}; // R24
         `REG_PW_SERVICE:    rd_nxt = {31'h0, svc_open_r}; // R24
         `REG_UNIT_SERIAL:   rd_nxt = UNIT_SERIAL; // R1
         `REG_ERROR_MIN:     rd_nxt = err_min; // R2
         `REG_OK_MIN:        rd_nxt = ok_min; // R3
         `REG_DIAMETER_INFO: rd_nxt = DIAMETER; // R4
         `REG_FIRMWARE:      rd_nxt = FIRMWARE_VER; // R4
         `REG_NOMINAL_INFO:  rd_nxt = nominal_r; // R4
         `REG_RUN_STOP:      rd_nxt = run_stop_r;
         `REG_EMPTY_PIPE_EN: rd_nxt = empty_en_r;
         `REG_EMPTY_LIMIT:   rd_nxt = empty_limit_r;
         `REG_AVG_SAMPLES:   rd_nxt = avg_r;
         `REG_LOW_FLOW_CUT:  rd_nxt = cut_r;
         `REG_DIR_INVERT:    rd_nxt = inv_r;
         `REG_NOMINAL_USER:  rd_nxt = nominal_r;
         `REG_SLAVE_ADDR:    rd_nxt = addr_r;
         `REG_BIT_RATE:      rd_nxt = rate_r;
         `REG_PARITY:        rd_nxt = parity_r;
         `REG_PWRUP_DELAY:   rd_nxt = delay_r;
         `REG_SIM_SWITCH:    rd_nxt = sim_sw_r;
         `REG_SIM_FLOW:      rd_nxt = sim_flow_r;
         default:            rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ack       <= 1'b0;
         o_rdata     <= 32'h0000_0000;
         o_exception <= `EXC_NONE;
      end else begin
         o_ack <= i_req;
         // answer stands until the next request
         if (i_req) begin
            o_exception <= wr_ok ? `EXC_NONE : `EXC_ILLEGAL_ADDR; // R23
            o_rdata     <= (wr_ok && !i_write) ? rd_nxt : 32'h0000_0000;
         end
      end
   end
endmodule // settings_bank

//--- settings_bank_map.vh
// register numbers, reset values and timing counts of the settings bank
`ifndef SETTINGS_BANK_MAP_VH
`define SETTINGS_BANK_MAP_VH

`define REG_PW_USER        16'h0002
`define REG_PW_SERVICE     16'h0004
`define REG_UNIT_SERIAL    16'h03e8
`define REG_ERROR_MIN      16'h03ea
`define REG_OK_MIN         16'h03ec
`define REG_DIAMETER_INFO  16'h03ee
`define REG_FIRMWARE       16'h03f0
`define REG_NOMINAL_INFO   16'h03f2
`define REG_RUN_STOP       16'h07d0
`define REG_EMPTY_PIPE_EN  16'h07d2
`define REG_EMPTY_LIMIT    16'h07d4
`define REG_AVG_SAMPLES    16'h07d6
`define REG_LOW_FLOW_CUT   16'h07d8
`define REG_DIR_INVERT     16'h07da
`define REG_NOMINAL_USER   16'h07dc
`define REG_CLEAN_TRIG     16'h07de
`define REG_AUX_CLEAR      16'h07e0
`define REG_SLAVE_ADDR     16'h07e2
`define REG_BIT_RATE       16'h07e4
`define REG_PARITY         16'h07e6
`define REG_PWRUP_DELAY    16'h07e8
`define REG_OK_CLEAR       16'h0bb8
`define REG_ERR_CLEAR      16'h0bba
`define REG_TOTAL_CLEAR    16'h0bbc
`define REG_NEG_CLEAR      16'h0bbe
`define REG_POS_CLEAR      16'h0bc0
`define REG_SIM_SWITCH     16'h0bc2
`define REG_SIM_FLOW       16'h0bc4

`define USER_PASSWORD      32'h0000_0457
`define SERVICE_PASSWORD   32'h0000_0d05

`define RST_RUN_STOP       32'h0000_0001
`define RST_EMPTY_PIPE_EN  32'h0000_0001
`define RST_EMPTY_LIMIT    32'h0000_00bc
`define RST_AVG_SAMPLES    32'h0000_000f
`define RST_LOW_FLOW_CUT   32'h0000_0003
`define RST_DIR_INVERT     32'h0000_0000
`define RST_NOMINAL_USER   32'h0000_0e10
`define RST_SLAVE_ADDR     32'h0000_0001
`define RST_BIT_RATE       32'h0000_2580
`define RST_PARITY         32'h0000_0003
`define RST_PWRUP_DELAY    32'h0000_000f
`define RST_SIM_SWITCH     32'h0000_0001

`define EXC_NONE           8'h00
`define EXC_ILLEGAL_ADDR   8'h02

`define CLK_HZ             100000000
`define MINUTE_S           60
`define SECOND_S           1

`endif

//--- minute_counter.v
// per-minute event counter with clear
`timescale 1ns/100ps
module minute_counter #(
   parameter WIDTH = 32
) (
   input  wire             i_clk,
   input  wire             i_rst_n,
   input  wire             i_minute,
   input  wire             i_count_en,
   input  wire             i_clear,
   output reg  [WIDTH-1:0] o_count
);
   // clear wins because it is an explicit reset of the total
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count <= {WIDTH{1'b0}};
      end else if (i_clear) begin
         o_count <= {WIDTH{1'b0}};
      end else if (i_minute && i_count_en) begin
         o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule // minute_counter

//--- tick_divider.v
// divider producing a one-cycle enable every DIV cycles of i_tick_in
`timescale 1ns/100ps
module tick_divider #(
   parameter DIV = 100
) (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_tick_in,
   output reg  o_tick
);
   reg [31:0] cnt_r;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r  <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (i_tick_in) begin
            if (cnt_r == DIV - 1) begin
               cnt_r  <= 32'h0000_0000;
               o_tick <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 32'h0000_0001;
            end
         end
      end
   end
endmodule // tick_divider

//--- register_master_model.sv
// modbus master stand-in driving the request port of the bank
`timescale 1ns/100ps
module register_master_model (
   input  wire        i_clk,
   input  wire        i_go,
   input  wire        i_write,
   input  wire [15:0] i_reg,
   input  wire [7:0]  i_count,
   input  wire [31:0] i_wdata,
   output wire        o_req,
   output wire        o_write,
   output wire [15:0] o_reg,
   output wire [7:0]  o_count,
   output wire [31:0] o_wdata
);
   reg        last_wr_r   = 1'b0;
   reg [15:0] last_reg_r  = 16'h0000;
   reg [31:0] last_data_r = 32'h0000_0000;
   always @(posedge i_clk) begin
      if (i_go) begin
         last_wr_r   <= i_write;
         last_reg_r  <= i_reg;
         last_data_r <= i_wdata;
      end
   end
   // released write, register and data lines show the inverse of the last value; count shows zero
   assign o_req   = i_go;
   assign o_write = i_go ? i_write : ~last_wr_r;
   assign o_reg   = i_go ? i_reg : ~last_reg_r;
   assign o_count = i_go ? i_count : 8'h00;
   assign o_wdata = i_go ? i_wdata : ~last_data_r;
endmodule // register_master_model

//--- settings_bank_monitor.sv
// concurrent checks on the ports of the settings bank
`timescale 1ns/100ps
`include "settings_bank_map.vh"
module settings_bank_monitor (
   input wire        i_clk,
   input wire        i_rst_n,
   input wire        i_req,
   input wire        i_write,
   input wire [15:0] i_reg,
   input wire [7:0]  i_count,
   input wire [31:0] i_wdata,
   input wire        o_ack,
   input wire [31:0] o_rdata,
   input wire [7:0]  o_exception,
   input wire        o_clear_total,
   input wire        o_clean_start,
   input wire [1:0]  o_parity_code,
   input wire        o_parity_en,
   input wire        o_parity_odd,
   input wire        o_two_stop
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ack_follows_req_a: assert property (i_req |=> o_ack)
      else $error("ack missing after request");
   ack_needs_req_a: assert property (!i_req |=> !o_ack)
      else $error("ack without request");
   odd_reg_refused_a: assert property (i_req && i_reg[0] |=>
      o_exception == `EXC_ILLEGAL_ADDR)
      else $error("odd register not refused");
   bad_count_refused_a: assert property (i_req && i_count != 8'h02 |=>
      o_exception == `EXC_ILLEGAL_ADDR && o_rdata == 32'h0)
      else $error("wrong count not refused");
   info_write_refused_a: assert property (i_req && i_write && i_reg >= `REG_UNIT_SERIAL
      && i_reg <= `REG_NOMINAL_INFO |=> o_exception == `EXC_ILLEGAL_ADDR)
      else $error("info write not refused");
   answer_holds_a: assert property (!i_req |=> $stable(o_rdata) && $stable(o_exception))
      else $error("answer changed without request");
   total_clear_cause_a: assert property (o_clear_total |-> $past(i_req && i_write
      && i_reg == `REG_TOTAL_CLEAR && i_wdata != 32'h0))
      else $error("total clear without its write");
   clean_start_cause_a: assert property (o_clean_start |-> $past(i_req && i_write
      && i_reg == `REG_CLEAN_TRIG && i_wdata == 32'h1))
      else $error("cleaning without its write");
   parity_framing_a: assert property (o_parity_en == !o_parity_code[1]
      && o_parity_odd == (o_parity_code == 2'h1)
      && o_two_stop == (o_parity_code == 2'h2))
      else $error("framing does not match parity code");
endmodule // settings_bank_monitor
bind settings_bank settings_bank_monitor u_monitor (.i_clk, .i_rst_n, .i_req, .i_write,
   .i_reg, .i_count, .i_wdata, .o_ack, .o_rdata, .o_exception, .o_clear_total,
   .o_clean_start, .o_parity_code, .o_parity_en, .o_parity_odd, .o_two_stop);

//--- settings_bank_test.sv
// self-checking bench of the settings bank
`timescale 1ns/100ps
`include "settings_bank_map.vh"
module settings_bank_test;
   localparam [31:0] SER = 32'h0262_59ff;
   reg         i_clk = 1'b0, i_rst_n = 1'b0, go = 1'b0, wr = 1'b0;
   reg  [15:0] rg = 16'h0000;
   reg  [7:0]  cnt = 8'h02;
   reg  [31:0] wd = 32'h0, i_empty_data = 32'h0, i_flow = 32'h0000_0500;
   reg         i_meas_ok = 1'b0, i_meas_error = 1'b0, i_pipe_empty = 1'b0, i_flow_neg = 1'b0;
   reg  [31:0] rd;
   reg  [7:0]  ex;
   reg  [4:0]  pl;
   integer     n_errors = 0, n_tests = 0, i, k;
   wire        i_req, i_write, o_ack, o_total_enable, o_excitation_off, o_empty_pipe_error;
   wire [15:0] i_reg;
   wire [7:0]  i_count, o_exception, o_slave_address;
   wire [31:0] i_wdata, o_rdata, o_nominal_flow, o_flow_used, o_bit_rate;
   wire [4:0]  o_avg_samples;
   wire [2:0]  o_low_flow_cut;
   wire [1:0]  o_parity_code;
   wire        o_flow_neg, o_clean_start, o_clear_aux, o_clear_total, o_clear_neg;
   wire        o_clear_pos, o_parity_en, o_parity_odd, o_two_stop;
   register_master_model u_master (.i_clk, .i_go(go), .i_write(wr), .i_reg(rg),
      .i_count(cnt), .i_wdata(wd), .o_req(i_req), .o_write(i_write), .o_reg(i_reg),
      .o_count(i_count), .o_wdata(i_wdata));
   settings_bank #(.UNIT_SERIAL(SER), .CYCLES_PER_S(10), .SECONDS_PER_M(3)) DUT (
      .i_clk, .i_rst_n, .i_req, .i_write, .i_reg, .i_count, .i_wdata, .o_ack, .o_rdata,
      .o_exception, .i_meas_ok, .i_meas_error, .i_pipe_empty, .i_empty_data, .i_flow,
      .i_flow_neg, .o_total_enable, .o_excitation_off, .o_empty_pipe_error, .o_avg_samples,
      .o_low_flow_cut, .o_nominal_flow, .o_flow_used, .o_flow_neg, .o_clean_start,
      .o_clear_aux, .o_clear_total, .o_clear_neg, .o_clear_pos, .o_slave_address,
      .o_bit_rate, .o_parity_code, .o_parity_en, .o_parity_odd, .o_two_stop);
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   // ==========================================
   // tasks
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task acc(input w, input [15:0] r, input [31:0] d);
      begin
         @(negedge i_clk);
         wr = w;
         rg = r;
         wd = d;
         go = 1'b1;
         @(negedge i_clk);
         go = 1'b0;
         chk({31'h0, o_ack}, 32'h1);
         rd = o_rdata;
         ex = o_exception;
         pl = {o_clean_start, o_clear_aux, o_clear_total, o_clear_neg, o_clear_pos};
         @(negedge i_clk);
      end
   endtask
   task acx(input w, input [15:0] r, input [31:0] d, input [7:0] e);
      begin
         acc(w, r, d);
         chk({24'h0, ex}, {24'h0, e});
      end
   endtask
   task rx(input [15:0] r, input [31:0] e);
      begin
         acc(1'b0, r, 32'h0);
         chk(rd, e);
      end
   endtask
   function [31:0] rst_val(input integer n);
      case (n)
         0: rst_val = `RST_RUN_STOP;
         1: rst_val = `RST_EMPTY_PIPE_EN;
         2: rst_val = `RST_EMPTY_LIMIT;
         3: rst_val = `RST_AVG_SAMPLES;
         4: rst_val = `RST_LOW_FLOW_CUT;
         5: rst_val = `RST_DIR_INVERT;
         6: rst_val = `RST_NOMINAL_USER;
         9: rst_val = `RST_SLAVE_ADDR;
         10: rst_val = `RST_BIT_RATE;
         11: rst_val = `RST_PARITY;
         12: rst_val = `RST_PWRUP_DELAY;
         default: rst_val = 32'h0;
      endcase
   endfunction
   task give_verdict;
      begin
         $display("errors %0d, checks %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_errors = n_errors + 1;
      give_verdict;
   end
   // ==========================================
   // tests
   initial begin
      repeat (16) @(negedge i_clk);
      i_rst_n = 1'b1;
      chk({24'h0, o_slave_address}, `RST_SLAVE_ADDR);
      chk(o_bit_rate, `RST_BIT_RATE);
      chk({27'h0, o_avg_samples, o_low_flow_cut}, 32'h7b);
      chk({31'h0, o_total_enable}, 32'h0);
      rx(`REG_UNIT_SERIAL, SER);
      rx(`REG_FIRMWARE, 32'h64);
      rx(`REG_DIAMETER_INFO, 32'h32);
      rx(`REG_NOMINAL_INFO, `RST_NOMINAL_USER);
      acx(1'b1, `REG_FIRMWARE, 32'h5, `EXC_ILLEGAL_ADDR);
      acx(1'b0, `REG_RUN_STOP, 32'h0, `EXC_ILLEGAL_ADDR);
      rx(`REG_PW_USER, 32'h0);
      acx(1'b1, `REG_PW_USER, `USER_PASSWORD, `EXC_NONE);
      rx(`REG_PW_USER, 32'h1);
      for (i = 0; i < 13; i = i + 1)
         rx(`REG_RUN_STOP + 2 * i, rst_val(i));
      acx(1'b1, `REG_RUN_STOP, 32'h0, `EXC_NONE);
      chk({31'h0, o_total_enable}, 32'h0);
      repeat (160) @(negedge i_clk);
      chk({31'h0, o_total_enable}, 32'h1);
      acx(1'b1, `REG_RUN_STOP, 32'h1, `EXC_NONE);
      chk({31'h0, o_total_enable}, 32'h0);
      cnt = 8'h03;
      acx(1'b0, `REG_RUN_STOP, 32'h0, `EXC_ILLEGAL_ADDR);
      cnt = 8'h02;
      acx(1'b0, `REG_RUN_STOP + 1, 32'h0, `EXC_ILLEGAL_ADDR);
      acx(1'b0, 16'h0600, 32'h0, `EXC_ILLEGAL_ADDR);
      acx(1'b1, `REG_AVG_SAMPLES, 32'h1e, `EXC_NONE);
      chk({27'h0, o_avg_samples}, 32'h1e);
      acx(1'b1, `REG_LOW_FLOW_CUT, 32'h5, `EXC_NONE);
      chk({29'h0, o_low_flow_cut}, 32'h5);
      acx(1'b1, `REG_SLAVE_ADDR, 32'hf7, `EXC_NONE);
      chk({24'h0, o_slave_address}, 32'hf7);
      acx(1'b1, `REG_BIT_RATE, 32'h1_c200, `EXC_NONE);
      chk(o_bit_rate, 32'h1_c200);
      acx(1'b1, `REG_NOMINAL_USER, 32'h0225_5100, `EXC_NONE);
      chk(o_nominal_flow, 32'h0225_5100);
      for (i = 0; i < 4; i = i + 1) begin
         acx(1'b1, `REG_PARITY, i, `EXC_NONE);
         chk({27'h0, o_parity_code, o_parity_en, o_parity_odd, o_two_stop},
            {27'h0, i[1:0], i < 2, i == 1, i == 2});
      end
      acx(1'b1, `REG_DIR_INVERT, 32'h1, `EXC_NONE);
      chk({31'h0, o_flow_neg}, 32'h1);
      acx(1'b1, `REG_DIR_INVERT, 32'h0, `EXC_NONE);
      chk({31'h0, o_flow_neg}, 32'h0);
      i_pipe_empty = 1'b1;
      repeat (2) @(negedge i_clk);
      chk({31'h0, o_excitation_off}, 32'h0);
      acx(1'b1, `REG_EMPTY_PIPE_EN, 32'h0, `EXC_NONE);
      chk({30'h0, o_excitation_off, o_empty_pipe_error}, 32'h3);
      i_pipe_empty = 1'b0;
      i_empty_data = 32'hc8;
      repeat (2) @(negedge i_clk);
      chk({31'h0, o_empty_pipe_error}, 32'h1);
      acx(1'b1, `REG_EMPTY_LIMIT, 32'h3e7, `EXC_NONE);
      chk({31'h0, o_empty_pipe_error}, 32'h0);
      acx(1'b1, `REG_CLEAN_TRIG, 32'h1, `EXC_NONE);
      chk({27'h0, pl}, 32'h10);
      acx(1'b1, `REG_CLEAN_TRIG, 32'h2, `EXC_NONE);
      chk({27'h0, pl}, 32'h0);
      acx(1'b1, `REG_AUX_CLEAR, 32'h5, `EXC_NONE);
      chk({27'h0, pl}, 32'h08);
      acx(1'b1, `REG_SIM_FLOW, 32'h1234, `EXC_ILLEGAL_ADDR);
      rx(`REG_PW_SERVICE, 32'h0);
      acx(1'b1, `REG_PW_SERVICE, `SERVICE_PASSWORD, `EXC_NONE);
      rx(`REG_PW_SERVICE, 32'h1);
      for (i = 0; i < 3; i = i + 1) begin
         acx(1'b1, `REG_TOTAL_CLEAR + 2 * i, 32'h1, `EXC_NONE);
         chk({27'h0, pl}, 32'h04 >> i);
      end
      acx(1'b1, `REG_SIM_FLOW, 32'h1234, `EXC_NONE);
      acx(1'b1, `REG_SIM_SWITCH, 32'h0, `EXC_NONE);
      chk(o_flow_used, 32'h1234);
      acx(1'b1, `REG_SIM_SWITCH, 32'h1, `EXC_NONE);
      chk(o_flow_used, i_flow);
      for (k = 0; k < 2; k = k + 1) begin
         acx(1'b1, `REG_OK_CLEAR + 2 * k, 32'h1, `EXC_NONE);
         if (k == 0)
            i_meas_ok = 1'b1;
         else
            i_meas_error = 1'b1;
         repeat (120) @(negedge i_clk);
         i_meas_ok = 1'b0;
         i_meas_error = 1'b0;
         rx(`REG_OK_MIN - 2 * k, 32'h4);
         acx(1'b1, `REG_OK_CLEAR + 2 * k, 32'h3, `EXC_NONE);
         rx(`REG_OK_MIN - 2 * k, 32'h0);
      end
      acx(1'b1, `REG_PW_USER, 32'h0, `EXC_NONE);
      rx(`REG_PW_USER, 32'h0);
      acx(1'b0, `REG_RUN_STOP, 32'h0, `EXC_ILLEGAL_ADDR);
      give_verdict;
   end
endmodule // settings_bank_test
